/* hw/flash_cmd_pkg.sv */
// Purpose: Shared constants for the wrap-read, reset and discovery command block
// Assumes: Mode 0 link timing, opcodes one byte, addresses three bytes
// Notes:   Discovery header image lives here for the ROM; the bench keeps its own copy of the bytes
package flash_cmd_pkg;

    // Opcodes
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_WRAP_READ = 8'h0C;
    localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
    localparam logic [7:0] OP_SET_PARAM = 8'hC0;
    localparam logic [7:0] OP_RST_EN    = 8'h66;
    localparam logic [7:0] OP_RST       = 8'h99;
    localparam logic [7:0] OP_DISC_READ = 8'h5A;
    localparam logic [7:0] OP_QUAD_ON   = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF  = 8'hFF;

    // Phase lengths in bits, and bits moved per link clock
    localparam logic [5:0] OPC_BITS  = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] BYTE_BITS = 6'h08;
    localparam logic [5:0] STEP_SER  = 6'h01;
    localparam logic [5:0] STEP_QUAD = 6'h04;

    // Dummy clock counts and dummy field codes
    localparam logic [3:0] DUMMY_FOUR  = 4'h4;
    localparam logic [3:0] DUMMY_SIX   = 4'h6;
    localparam logic [3:0] DUMMY_DISC  = 4'h8;
    localparam logic [3:0] DUMMY_SERIAL = 4'h8;
    localparam logic [1:0] DSEL_SIX    = 2'h2;
    localparam logic [1:0] DSEL_UNDEF  = 2'h3;

    // Read parameter byte fields and defaults
    localparam int DSEL_LSB = 4;
    localparam int WSEL_LSB = 0;
    localparam logic [1:0] WSEL_DFLT = 2'h0;

    // Wrap masks for 8, 16, 32, 64 byte sections
    localparam logic [5:0] WRAP_MASK [4] = '{6'h07, 6'h0F, 6'h1F, 6'h3F};

    // Output lane enables
    localparam logic [3:0] OE_SERIAL = 4'h2;
    localparam logic [3:0] OE_QUAD   = 4'hF;

    // Discovery area
    localparam logic [23:0] DISC_SIZE = 24'h00_0800;
    localparam logic [7:0]  ERASED    = 8'hFF;
    localparam logic [7:0]  VENDOR_ID_BYTE = 8'h5C; // Arbitrary value
    localparam int          HDR_LEN   = 24;
    localparam logic [7:0]  HDR_BYTES [HDR_LEN] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hFF,
        8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF,
        VENDOR_ID_BYTE, 8'h00, 8'h01, 8'h02, 8'h80, 8'h00, 8'h00, 8'hFF};

    // Recovery interval after a software reset
    localparam int T_RST_US        = 30;
    localparam int REF_CLK_MHZ     = 200;
    localparam int RST_CYCLES_DFLT = T_RST_US * REF_CLK_MHZ;

    // Frame state machine
    typedef enum logic [5:0] {
        ST_CMD   = 6'b00_0001,
        ST_ADDR  = 6'b00_0010,
        ST_DUMMY = 6'b00_0100,
        ST_DATA  = 6'b00_1000,
        ST_PARAM = 6'b01_0000,
        ST_IDLE  = 6'b10_0000
    } frame_state_e;

endpackage

/* hw/disc_rom_if.sv */
// Purpose: Address and data pair between the frame logic and the discovery ROM
// Assumes: Combinational lookup on the link clock side
// Notes:   None
`timescale 1ns/10ps
interface disc_rom_if;
    logic [23:0] addr;
    logic [7:0]  data;
    modport user (output addr, input data);
    modport rom  (input addr, output data);
endinterface

/* hw/sync_2ff.sv */
// Purpose: Two flop level synchroniser
// Assumes: Input is a slow level or a toggle
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module sync_2ff (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // Two stages, nothing taps the first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* hw/disc_rom.sv */
// Purpose: Read-only discovery area lookup
// Assumes: Address is stable for half a link clock before use
// Notes:   Only the header image is programmed, the rest reads erased
`timescale 1ns/10ps
module disc_rom
    import flash_cmd_pkg::*;
(
    disc_rom_if.rom romPort
);
    wire inHeader;

    // Header bytes from the image, everything else erased
    assign inHeader     = romPort.addr < 24'(HDR_LEN);
    assign romPort.data = inHeader ? HDR_BYTES[romPort.addr[4:0]]
                                   : ERASED;
endmodule

/* hw/wrap_read_reset_discovery_cmds.sv */
// Purpose: Link-side handling of wrap read, read parameters, reset, discovery
// Assumes: Mode 0 link, chip select frames every command, array fed by arrayData
// Notes:   Frame logic runs on the link clock; recovery timing on ref_clk
`timescale 1ns/10ps
// Summary of operation
// - Quad wrap read wraps within section
// - Quad C0h sets dummy count and wrap
// - Serial mode rejects C0h, fixed dummies
// - Defaults: 8-byte wrap, 4 dummy clocks
// - Dummy field 00/01 four, 10 six
// - Wrap field gives 8/16/32/64 bytes
// - Software reset restores power-on volatile state
// - 66h and 99h work both modes
// - 99h must directly follow 66h
// - Commands ignored during reset recovery
// - 5Ah, 24-bit address, 8 dummy clocks
// - Discovery bits driven on falling edge
// - Chip select high ends output
// - 2048-byte area, unwritten reads FFh
// - Signature and revision header bytes
// - Two parameter headers as specified
// - Quad mode entry needs quad enable
module wrap_read_reset_discovery_cmds
    import flash_cmd_pkg::*;
#(
    parameter int unsigned RECOVERY_CYCLES = RST_CYCLES_DFLT
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        serialClk,
    input  wire logic        chipSelN,
    input  wire logic [3:0]  ioIn,
    output logic      [3:0]  ioOut,
    output logic      [3:0]  ioOe,
    input  wire logic        quadEnableBit,
    output logic      [23:0] arrayAddr,
    input  wire logic [7:0]  arrayData,
    output logic             quadCommandMode,
    output logic      [3:0]  readDummyClocks,
    output logic      [1:0]  wrapSelect,
    output logic             softResetPulse,
    output logic             recovering
);

    disc_rom_if romBus ();

    // Frame registers
    frame_state_e state_q, state_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [23:0] sh_q;
    logic [23:0] addr_q, addr_d;
    logic        readDisc_q, readWrap_q;
    logic [3:0]  dummyNeed_q;
    logic        readDisc_d, readWrap_d;
    logic [3:0]  dummyNeed_d;

    // Persistent link-side settings
    logic        quadMode_q;
    logic        armed_q;
    logic        rstTgl_q;
    logic [3:0]  dummyCnt_q;
    logic [1:0]  wrapSel_q;

    // Output flops on the falling edge
    logic [3:0]  ioOut_q, ioOe_q;

    // Reference clock side, then the synchronised signals on the link clock
    logic        tglSync, tglPrev_q, softResetPulse_q, recovering_q, doneTgl_q;
    logic [15:0] recovCnt_q;
    logic        recovSck, qeSck, doneSck;

    wire         frameRst;
    wire  [5:0]  step;
    wire  [23:0] shNext;
    wire  [7:0]  opByte;
    wire  [5:0]  cntStep, cntOne;
    wire         opDone, cmdOk, paramDone, byteDone, addrDone, dummyDone;
    wire         isRstEn, isRst, isQuadOn, isQuadOff, isParam, isDisc;
    wire         isQuadRead, isSerRead, rstAccept, rstPend;
    wire  [1:0]  dselField, wselField;
    wire  [5:0]  wmask, lowInc;
    wire  [23:0] nextAddr;
    wire  [7:0]  curByte;
    wire  [2:0]  bitIdx;
    wire  [3:0]  lanes;

    // Decode of the dummy field; 11 keeps the current count
    function automatic logic [3:0] dummy_decode(input logic [1:0] sel,
                                                input logic [3:0] cur);
        logic [3:0] res;
        res = DUMMY_FOUR;
        if (sel == DSEL_SIX) begin
            res = DUMMY_SIX;
        end
        if (sel == DSEL_UNDEF) begin
            res = cur;
        end
        return res;
    endfunction

    disc_rom romInst (
        .romPort (romBus)
    );

    // Chip select high is the frame's own end, so it resets the frame
    assign frameRst = rst | chipSelN;

    // Crossings between the link and ref_clk domains; the reset toggle goes to ref_clk
    sync_2ff qeSyncInst (
        .clk (serialClk),
        .rst (rst),
        .d   (quadEnableBit),
        .q   (qeSck)
    );
    sync_2ff recovSyncInst (
        .clk (serialClk),
        .rst (rst),
        .d   (recovering_q),
        .q   (recovSck)
    );
    sync_2ff tglSyncInst (
        .clk (ref_clk),
        .rst (rst),
        .d   (rstTgl_q),
        .q   (tglSync)
    );
    sync_2ff doneSyncInst (
        .clk (serialClk),
        .rst (rst),
        .d   (doneTgl_q),
        .q   (doneSck)
    );

    // Shift and counter arithmetic
    assign step    = quadMode_q ? STEP_QUAD : STEP_SER;
    assign shNext  = quadMode_q ? {sh_q[19:0], ioIn} : {sh_q[22:0], ioIn[0]};
    assign opByte  = shNext[7:0];
    assign cntStep = cnt_q + step;
    assign cntOne  = cnt_q + 6'h01;

    // Phase completion
    assign opDone    = (state_q == ST_CMD) && (cntStep == OPC_BITS);
    assign addrDone  = (state_q == ST_ADDR) && (cntStep == ADDR_BITS);
    assign dummyDone = (state_q == ST_DUMMY) && (cntOne[3:0] == dummyNeed_q);
    assign byteDone  = (state_q == ST_DATA) && (cntStep == BYTE_BITS);
    assign paramDone = (state_q == ST_PARAM) && (cntStep == BYTE_BITS);

    // A pending or running recovery swallows every opcode
    assign cmdOk = opDone && !rstPend && !recovSck;

    // Opcode decode
    assign isRstEn    = opByte == OP_RST_EN;
    assign isRst      = opByte == OP_RST;
    assign isQuadOn   = !quadMode_q && (opByte == OP_QUAD_ON);
    assign isQuadOff  = quadMode_q && (opByte == OP_QUAD_OFF);
    assign isParam    = quadMode_q && (opByte == OP_SET_PARAM);
    assign isDisc     = opByte == OP_DISC_READ;
    assign isQuadRead = quadMode_q && ((opByte == OP_FAST_READ) ||
                        (opByte == OP_WRAP_READ) || (opByte == OP_QUAD_IO));
    assign isSerRead  = !quadMode_q && (opByte == OP_FAST_READ);
    assign rstAccept  = cmdOk && isRst && armed_q;

    // Parameter byte fields; other bits are dropped
    assign dselField = shNext[DSEL_LSB +: 2];
    assign wselField = shNext[WSEL_LSB +: 2];

    // Address advance, wrapping within the section for 0Ch
    assign wmask    = WRAP_MASK[wrapSel_q];
    assign lowInc   = addr_q[5:0] + 6'h01;
    assign nextAddr = readWrap_q
                    ? {addr_q[23:6], (addr_q[5:0] & ~wmask) | (lowInc & wmask)}
                    : addr_q + 24'h00_0001;

    // Byte source and the lane slice for this clock
    assign romBus.addr = addr_q;
    assign curByte     = readDisc_q ? romBus.data : arrayData;
    assign bitIdx      = 3'h7 - cnt_q[2:0];
    assign lanes       = quadMode_q ? (cnt_q[2] ? curByte[3:0] : curByte[7:4])
                                    : {2'b00, curByte[bitIdx], 1'b0};

    // Frame state machine
    always_comb begin
        state_d     = state_q;
        cnt_d       = cntStep;
        addr_d      = addr_q;
        readDisc_d  = readDisc_q;
        readWrap_d  = readWrap_q;
        dummyNeed_d = dummyNeed_q;
        unique case (state_q)
            ST_CMD: begin
                if (opDone) begin
                    cnt_d   = '0;
                    state_d = ST_IDLE;
                    if (cmdOk && (isDisc || isQuadRead || isSerRead)) begin
                        state_d     = ST_ADDR;
                        readDisc_d  = isDisc;
                        readWrap_d  = isQuadRead && (opByte == OP_WRAP_READ);
                        dummyNeed_d = isDisc ? DUMMY_DISC
                                    : (quadMode_q ? dummyCnt_q
                                                  : DUMMY_SERIAL);
                    end else if (cmdOk && isParam) begin
                        state_d = ST_PARAM;
                    end
                end
            end
            ST_ADDR: begin
                if (addrDone) begin
                    cnt_d   = '0;
                    addr_d  = shNext;
                    state_d = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                cnt_d = cntOne;
                if (dummyDone) begin
                    cnt_d   = '0;
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (byteDone) begin
                    cnt_d  = '0;
                    addr_d = nextAddr;
                end
            end
            ST_PARAM: begin
                if (paramDone) begin
                    cnt_d   = '0;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                cnt_d = '0;
            end
        endcase
    end

    // Frame registers, cleared whenever chip select is high
    always_ff @(posedge serialClk or posedge frameRst) begin
        if (frameRst) begin
            state_q     <= ST_CMD;
            cnt_q       <= '0;
            sh_q        <= '0;
            addr_q      <= '0;
            readDisc_q  <= 1'b0;
            readWrap_q  <= 1'b0;
            dummyNeed_q <= DUMMY_FOUR;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            sh_q        <= shNext;
            addr_q      <= addr_d;
            readDisc_q  <= readDisc_d;
            readWrap_q  <= readWrap_d;
            dummyNeed_q <= dummyNeed_d;
        end
    end

    // Reset arming and mode switching
    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            armed_q    <= 1'b0;
            quadMode_q <= 1'b0;
            rstTgl_q   <= 1'b0;
        end else if (cmdOk) begin
            armed_q <= isRstEn && !rstAccept;
            if (rstAccept) begin
                quadMode_q <= 1'b0;
                rstTgl_q   <= !rstTgl_q;
            end else if (isQuadOn && qeSck) begin
                quadMode_q <= 1'b1;
            end else if (isQuadOff) begin
                quadMode_q <= 1'b0;
            end
        end
    end

    // Read parameters; a reset restores the power-on values
    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            dummyCnt_q <= DUMMY_FOUR;
            wrapSel_q  <= WSEL_DFLT;
        end else if (rstAccept) begin
            dummyCnt_q <= DUMMY_FOUR;
            wrapSel_q  <= WSEL_DFLT;
        end else if (paramDone) begin
            dummyCnt_q <= dummy_decode(dselField, dummyCnt_q);
            wrapSel_q  <= wselField;
        end
    end

    // Pending until the slow side hands the toggle back; a level seen only
    // while the link clock runs would hang if the host idles through recovery
    assign rstPend = rstTgl_q ^ doneSck;

    // Output lanes change on the falling edge and float between frames
    always_ff @(negedge serialClk or posedge frameRst) begin
        if (frameRst) begin
            ioOut_q <= '0;
            ioOe_q  <= '0;
        end else if (state_q == ST_DATA) begin
            ioOut_q <= lanes;
            ioOe_q  <= quadMode_q ? OE_QUAD : OE_SERIAL;
        end else begin
            ioOut_q <= '0;
            ioOe_q  <= '0;
        end
    end

    // Recovery timer; the toggle keeps a short link frame from being lost
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tglPrev_q        <= 1'b0;
            doneTgl_q        <= 1'b0;
            softResetPulse_q <= 1'b0;
            recovering_q     <= 1'b0;
            recovCnt_q       <= '0;
        end else begin
            tglPrev_q        <= tglSync;
            softResetPulse_q <= tglSync ^ tglPrev_q;
            if (tglSync ^ tglPrev_q) begin
                recovering_q <= 1'b1;
                recovCnt_q   <= 16'(RECOVERY_CYCLES - 1);
            end else if (recovCnt_q != '0) begin
                recovCnt_q <= recovCnt_q - 16'h0001;
            end else begin
                recovering_q <= 1'b0;
                doneTgl_q    <= tglPrev_q;
            end
        end
    end

    // Ports from flops
    assign ioOut           = ioOut_q;
    assign ioOe            = ioOe_q;
    assign arrayAddr       = addr_q;
    assign quadCommandMode = quadMode_q;
    assign readDummyClocks = dummyCnt_q;
    assign wrapSelect      = wrapSel_q;
    assign softResetPulse  = softResetPulse_q;
    assign recovering      = recovering_q;

endmodule

/* bench/cmd_checker.sv */
// Purpose: Port-level checks on the wrap read, reset and discovery block
// Assumes: Recovery at least 8 ref_clk cycles
// Notes:   Lane enable, parameter and quad checks sample on serialClk; recovery and chip select checks on ref_clk
`timescale 1ns/10ps
module cmd_checker
    import flash_cmd_pkg::*;
#(
    parameter int unsigned RECOVERY_CYCLES = 20
) (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       serialClk,
    input wire logic       chipSelN,
    input wire logic [3:0] ioOe,
    input wire logic       quadEnableBit,
    input wire logic       quadCommandMode,
    input wire logic [3:0] readDummyClocks,
    input wire logic [1:0] wrapSelect,
    input wire logic       softResetPulse,
    input wire logic       recovering
);
    int unsigned recCnt_q;
    int unsigned recCnt_d;

    // Length of the current recovery run, zero outside it
    assign recCnt_d = recovering ? recCnt_q + 1 : 0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            recCnt_q <= 0;
        end else begin
            recCnt_q <= recCnt_d;
        end
    end

    // Recovery must hold at least eight cycles once opened
    sequence s_hold;
        recovering [*8];
    endsequence

    a_pulse_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        softResetPulse |=> !softResetPulse) else $error("reset pulse too long");
    a_pulse_opens_recovery: assert property (@(posedge ref_clk) disable iff (rst)
        softResetPulse |-> recovering && !$past(recovering)) else $error("recovery not opened");
    a_recovery_holds: assert property (@(posedge ref_clk) disable iff (rst)
        softResetPulse |-> s_hold) else $error("recovery dropped early");
    a_recovery_length: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(recovering) |-> recCnt_q == RECOVERY_CYCLES) else $error("recovery length wrong");
    a_reset_defaults: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(recovering) |-> !quadCommandMode && readDummyClocks == 4'h4 && wrapSelect == 2'h0)
        else $error("settings not restored");
    a_cs_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        chipSelN && $past(chipSelN) |-> ioOe == 4'h0) else $error("driving while deselected");
    a_oe_lanes: assert property (@(posedge serialClk) disable iff (rst)
        ioOe == 4'h0 || ioOe == 4'h2 || (ioOe == 4'hF && quadCommandMode))
        else $error("bad lane enables");
    a_serial_params_fixed: assert property (@(posedge serialClk) disable iff (rst)
        !$past(quadCommandMode) && ($changed(readDummyClocks) || $changed(wrapSelect))
        |-> readDummyClocks == 4'h4 && wrapSelect == 2'h0) else $error("serial mode changed params");
    a_quad_needs_enable: assert property (@(posedge serialClk) disable iff (rst)
        $rose(quadCommandMode) |-> $past(quadEnableBit, 3)) else $error("quad mode without enable");
endmodule

bind wrap_read_reset_discovery_cmds cmd_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) chk (
    .ref_clk(ref_clk), .rst(rst), .serialClk(serialClk), .chipSelN(chipSelN), .ioOe(ioOe),
    .quadEnableBit(quadEnableBit), .quadCommandMode(quadCommandMode),
    .readDummyClocks(readDummyClocks), .wrapSelect(wrapSelect),
    .softResetPulse(softResetPulse), .recovering(recovering));

/* bench/host_model.sv */
// Purpose: Host controller model that frames commands on the link
// Assumes: Mode 0, 48 ns link clock
// Notes:   Clock stands still between frames; idle lanes carry inverted data
`timescale 1ns/10ps
module host_model (
    output logic            serialClk,
    output logic            chipSelN,
    output logic      [3:0] ioIn,
    input  wire logic [3:0] ioOut
);
    logic [7:0] rdBuf [80];

    // Idle link at time zero
    initial begin
        serialClk = 1'b0;
        chipSelN  = 1'b1;
        ioIn      = 4'h0;
    end

    // Free clocks with chip select high, for the sync stages
    task automatic spin(input int n);
        repeat (n) begin
            #24 serialClk = 1'b1;
            #24 serialClk = 1'b0;
        end
    endtask

    // One link clock: lanes set while low, device output sampled on the rise
    task automatic tick(input logic [3:0] lanes, output logic [3:0] seen);
        ioIn = lanes;
        #24 serialClk = 1'b1;
        seen = ioOut;
        #24 serialClk = 1'b0;
    endtask

    // Opcode and payload MSB first, dummies, reads, then extra clocks
    task automatic frame(input bit quad, input logic [7:0] op, input logic [23:0] pay,
                         input int nBits, input int dummy, input int nRd, input int tail);
        logic [31:0] sh;
        logic [3:0]  s;
        int          step;
        step = quad ? 4 : 1;
        sh = {op, pay << (24 - nBits)};
        chipSelN = 1'b0;
        for (int i = 0; i < 8 + nBits; i += step) begin
            tick(quad ? sh[31:28] : {3'h0, sh[31]}, s);
            sh = sh << step;
        end
        repeat (dummy) tick(~ioIn, s);
        for (int b = 0; b < nRd; b++) begin
            for (int k = 0; k < 8; k += step) begin
                tick(~ioIn, s);
                rdBuf[b] = quad ? {rdBuf[b][3:0], s} : {rdBuf[b][6:0], s[1]};
            end
        end
        repeat (tail) tick(~ioIn, s);
        // Ending mid-byte is allowed; gap keeps frames apart
        chipSelN = 1'b1;
        ioIn = ~ioIn;
        #48;
    endtask
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the wrap read, reset and discovery block
// Assumes: Array byte is a fixed function of its address
// Notes:   Recovery shortened to 400 cycles so a whole frame fits inside it
`timescale 1ns/10ps
module tb_top;
    import flash_cmd_pkg::*;
    localparam int REC = 400;
    logic        ref_clk, rst, quadEnableBit, serialClk, chipSelN;
    logic        quadCommandMode, softResetPulse, recovering;
    logic [3:0]  ioIn, ioOut, ioOe, readDummyClocks;
    logic [1:0]  wrapSelect;
    logic [23:0] arrayAddr;
    logic [7:0]  arrayData;
    int          fails, checks_done, pulses, cycles;

    wrap_read_reset_discovery_cmds #(.RECOVERY_CYCLES(REC)) dut (
        .ref_clk(ref_clk), .rst(rst), .serialClk(serialClk), .chipSelN(chipSelN),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadEnableBit(quadEnableBit),
        .arrayAddr(arrayAddr), .arrayData(arrayData), .quadCommandMode(quadCommandMode),
        .readDummyClocks(readDummyClocks), .wrapSelect(wrapSelect),
        .softResetPulse(softResetPulse), .recovering(recovering));
    host_model host (.serialClk(serialClk), .chipSelN(chipSelN), .ioIn(ioIn), .ioOut(ioOut));

    function automatic logic [7:0] dat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    assign arrayData = dat(arrayAddr);

    // Clock, pulse count and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (softResetPulse === 1'b1) pulses++;
        if (cycles == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic waitRec(input logic lvl);
        for (int n = 0; n < 600 && recovering !== lvl; n++) @(posedge ref_clk);
        #1;
        check(recovering, lvl);
    endtask

    task automatic test_discovery();
        logic [7:0] hdr [24];
        hdr = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hFF,
                8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF,
                VENDOR_ID_BYTE, 8'h00, 8'h01, 8'h02, 8'h80, 8'h00, 8'h00, 8'hFF};
        check({quadCommandMode, wrapSelect, readDummyClocks}, 7'h04);
        host.frame(0, 8'h5A, 24'h00_0000, 24, 8, 26, 0);
        for (int i = 0; i < 24; i++) check(host.rdBuf[i], hdr[i]);
        check({host.rdBuf[24], host.rdBuf[25]}, 16'hFFFF);
        host.frame(0, 8'h5A, 24'h00_07FE, 24, 8, 4, 0);
        for (int i = 0; i < 4; i++) check(host.rdBuf[i], 8'hFF);
        host.frame(0, 8'h5A, 24'h00_0000, 24, 8, 1, 4);
        check(ioOe, 4'h0);
        host.frame(0, 8'h5A, 24'h00_0001, 24, 8, 1, 0);
        check(host.rdBuf[0], 8'h46);
        $display("test discovery done");
    endtask

    task automatic test_modes();
        host.frame(0, OP_FAST_READ, 24'h00_0042, 24, 8, 2, 0);
        for (int i = 0; i < 2; i++) check(host.rdBuf[i], dat(24'h00_0042 + i));
        host.frame(0, OP_SET_PARAM, 24'h00_0021, 8, 0, 0, 0);
        check({wrapSelect, readDummyClocks}, 6'h04);
        host.frame(0, OP_QUAD_ON, 24'h0, 0, 0, 0, 0);
        check(quadCommandMode, 1'b0);
        @(posedge ref_clk) #1 quadEnableBit = 1'b1;
        host.frame(0, OP_QUAD_ON, 24'h0, 0, 0, 0, 0);
        check(quadCommandMode, 1'b1);
        $display("test modes done");
    endtask

    task automatic test_wrap();
        logic [7:0] pb [4];
        logic [3:0] dm [4];
        int         len;
        pb = '{8'hC0, 8'h25, 8'hF2, 8'h1B};
        dm = '{4'h4, 4'h6, 4'h6, 4'h4};
        for (int k = 0; k < 4; k++) begin
            host.frame(1, OP_SET_PARAM, {16'h0, pb[k]}, 8, 0, 0, 0);
            check({wrapSelect, readDummyClocks}, {k[1:0], dm[k]});
            len = 8 << k;
            host.frame(1, OP_WRAP_READ, 24'h00_0105, 24, dm[k], len + 3, 0);
            for (int i = 0; i < len + 3; i++)
                check(host.rdBuf[i], dat(24'h00_0100 | ((5 + i) % len)));
        end
        host.frame(1, OP_FAST_READ, 24'h00_013E, 24, 4, 4, 0);
        for (int i = 0; i < 4; i++) check(host.rdBuf[i], dat(24'h00_013E + i));
        host.frame(1, OP_QUAD_IO, 24'h00_023F, 24, 4, 3, 0);
        for (int i = 0; i < 3; i++) check(host.rdBuf[i], dat(24'h00_023F + i));
        $display("test wrap done");
    endtask

    task automatic test_reset();
        int p0;
        p0 = pulses;
        host.frame(1, OP_RST_EN, 24'h0, 0, 0, 0, 0);
        host.frame(1, OP_SET_PARAM, 24'h00_0021, 8, 0, 0, 0);
        host.frame(1, OP_RST, 24'h0, 0, 0, 0, 0);
        #200;
        check({pulses, quadCommandMode, wrapSelect}, {p0, 3'h5});
        // No erase or program runs in this bench, so the pair is safe here
        host.frame(1, OP_RST_EN, 24'h0, 0, 0, 0, 0);
        host.frame(1, OP_RST, 24'h0, 0, 0, 0, 0);
        waitRec(1'b1);
        check({pulses, quadCommandMode, wrapSelect, readDummyClocks}, {p0 + 1, 7'h04});
        host.frame(0, OP_QUAD_ON, 24'h0, 0, 0, 0, 0);
        check(quadCommandMode, 1'b0);
        waitRec(1'b0);
        host.frame(0, 8'h00, 24'h0, 0, 0, 0, 0);
        host.frame(0, OP_RST_EN, 24'h0, 0, 0, 0, 0);
        host.frame(0, OP_RST, 24'h0, 0, 0, 0, 0);
        waitRec(1'b1);
        check(pulses, p0 + 2);
        $display("test reset done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reset with a few link clocks for the sync stages, then the tests
    initial begin
        rst = 1'b1;
        quadEnableBit = 1'b0;
        fails = 0;
        checks_done = 0;
        pulses = 0;
        cycles = 0;
        host.spin(2);
        repeat (5) @(posedge ref_clk);
        #1 rst = 1'b0;
        #48;
        test_discovery();
        test_modes();
        test_wrap();
        test_reset();
        tally_and_finish();
    end
endmodule
